// *** verilog/boot_select_regs.svh ***
// Constants of the double-reset startup selector.
// Assumes a 100 MHz system clock.
`ifndef BOOT_SELECT_REGS_SVH
`define BOOT_SELECT_REGS_SVH

`define CLK_HZ 100000000
`define CYC_PER_MS 100000
`define WINDOW_MS 750
`define LOADER_S 8
`define BOD_THRESHOLD_MV 4300
`define TIMER_W 32
`define TIMER_ONE 32'h0000_0001
`define TIMER_ZERO 32'h0000_0000
`define FADE_PRESC 18'h2faef
`define FADE_PRESC_W 18
`define DUTY_W 8
`define DUTY_MAX 8'hff
`define DUTY_MIN 8'h00

`endif

// *** verilog/boot_select_pkg.sv ***
// Types shared by the startup selector and its LED fader.
// Constants live in boot_select_regs.svh.
`include "boot_select_regs.svh"

package boot_select_pkg;
    typedef enum logic [2:0] {
        S_RESET,
        S_SELECT,
        S_WAIT,
        S_LOADER,
        S_USER
    } boot_state_e;

    typedef logic [`TIMER_W-1:0] timer_t;
    typedef logic [`DUTY_W-1:0] duty_t;
endpackage : boot_select_pkg

// *** verilog/led_fader.sv ***
// Triangle-fade PWM for the loader indicator LED.
// Assumes enable_i comes from logic on the same clock.
`timescale 1ns/1ps
`include "boot_select_regs.svh"

module led_fader
    import boot_select_pkg::*;
#(
    // Last prescaler count of one duty step
    parameter logic [`FADE_PRESC_W-1:0] STEP_LAST = `FADE_PRESC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    output logic pwm_o
);
    duty_t pwm_cnt_r, pwm_cnt_nxt;
    duty_t duty_r, duty_nxt;
    logic dir_up_r, dir_up_nxt;
    logic [`FADE_PRESC_W-1:0] presc_r, presc_nxt;
    logic pwm_r, pwm_nxt;

    always_comb begin
        pwm_cnt_nxt = pwm_cnt_r + 8'h01;
        duty_nxt = duty_r;
        dir_up_nxt = dir_up_r;
        presc_nxt = presc_r + 18'h00001;
        pwm_nxt = enable_i && (pwm_cnt_r < duty_r);
        if (!enable_i) begin
            // Restart dark so every loader entry fades in visibly
            duty_nxt = `DUTY_MIN;
            dir_up_nxt = 1'b1;
            presc_nxt = 18'h00000;
        end else if (presc_r == STEP_LAST) begin
            presc_nxt = 18'h00000;
            if (dir_up_r) begin
                if (duty_r == `DUTY_MAX) begin
                    dir_up_nxt = 1'b0;
                end else begin
                    duty_nxt = duty_r + 8'h01;
                end
            end else begin
                if (duty_r == `DUTY_MIN) begin
                    dir_up_nxt = 1'b1;
                end else begin
                    duty_nxt = duty_r - 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwm_cnt_r <= 8'h00;
            duty_r <= 8'h00;
            dir_up_r <= 1'b1;
            presc_r <= 18'h00000;
            pwm_r <= 1'b0;
        end else begin
            pwm_cnt_r <= pwm_cnt_nxt;
            duty_r <= duty_nxt;
            dir_up_r <= dir_up_nxt;
            presc_r <= presc_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    assign pwm_o = pwm_r;
endmodule : led_fader

// *** verilog/double_reset_boot_selector.sv ***
// Startup selector: single reset runs the user program, double reset enters loader.
// Assumes rst_n_i is power-on only; the reset button and brown-out arrive as pins.
`timescale 1ns/1ps
`include "boot_select_regs.svh"

// Functional notes
// - After every reset the selector decides first between user program and loader.
// - One reset: wait 750 ms, then start the user program.
// - Second reset within 750 ms of the first enters loader mode.
// - Loader leaves after 8 s unless commands began; after that no timeout.
// - Loader mode fades the yellow LED in and out repeatedly.
// - Brown-out detection always on; supply below 4.3 V resets the device.
// - Selector never clears the brown-out reset cause flag.
// - Running user program may force loader mode on a USB request.
module double_reset_boot_selector
    import boot_select_pkg::*;
#(
    parameter int unsigned WINDOW_CYCLES = `WINDOW_MS * `CYC_PER_MS,
    parameter int unsigned LOADER_CYCLES = `LOADER_S * `CLK_HZ,
    // Fade step length; shortened only so a bench can see the fade
    parameter logic [`FADE_PRESC_W-1:0] FADE_STEP_LAST = `FADE_PRESC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ext_reset_n_i,
    input wire logic brownout_i,
    input wire logic cmd_activity_i,
    input wire logic loader_request_i,
    input wire logic brownout_flag_clear_i,
    output logic core_reset_o,
    output logic run_user_o,
    output logic loader_active_o,
    output logic led_o,
    output logic brownout_reset_flag_o
);
    function automatic logic count_done(input timer_t cnt, input int unsigned limit);
        count_done = (cnt >= timer_t'(limit - 1));
    endfunction : count_done

    logic ext_meta_r, ext_sync_r;
    logic bod_meta_r, bod_sync_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_meta_r <= 1'b1;
            ext_sync_r <= 1'b1;
            bod_meta_r <= 1'b0;
            bod_sync_r <= 1'b0;
        end else begin
            ext_meta_r <= ext_reset_n_i;
            ext_sync_r <= ext_meta_r;
            bod_meta_r <= brownout_i;
            bod_sync_r <= bod_meta_r;
        end
    end

    logic reset_req;
    assign reset_req = !ext_sync_r || bod_sync_r;

    boot_state_e state_r, state_nxt;
    timer_t timer_r, timer_nxt;
    timer_t win_r, win_nxt;
    logic pending_r, pending_nxt;
    logic started_r, started_nxt;
    logic bor_flag_r, bor_flag_nxt;
    logic core_reset_r, core_reset_nxt;
    logic run_user_r, run_user_nxt;
    logic loader_r, loader_nxt;

    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r + `TIMER_ONE;
        win_nxt = win_r;
        pending_nxt = pending_r;
        started_nxt = started_r;
        bor_flag_nxt = bor_flag_r;
        // window runs on through button resets
        if (pending_r) begin
            if (count_done(win_r, WINDOW_CYCLES)) begin
                pending_nxt = 1'b0;
            end else begin
                win_nxt = win_r + `TIMER_ONE;
            end
        end
        // only user clear drops it; set wins
        if (brownout_flag_clear_i) begin
            bor_flag_nxt = 1'b0;
        end
        if (bod_sync_r) begin
            bor_flag_nxt = 1'b1;
        end
        case (state_r)
            S_RESET: begin
                if (!reset_req) begin
                    state_nxt = S_SELECT;
                end
            end
            S_SELECT: begin
                timer_nxt = `TIMER_ZERO;
                started_nxt = 1'b0;
                if (pending_r && !count_done(win_r, WINDOW_CYCLES)) begin
                    state_nxt = S_LOADER;
                    pending_nxt = 1'b0;
                end else begin
                    state_nxt = S_WAIT;
                    pending_nxt = 1'b1;
                    win_nxt = `TIMER_ZERO;
                end
            end
            S_WAIT: begin
                if (!pending_r) begin
                    state_nxt = S_USER;
                end
            end
            S_LOADER: begin
                if (cmd_activity_i) begin
                    started_nxt = 1'b1;
                end
                if (started_r) begin
                    timer_nxt = timer_r;
                end else if (!cmd_activity_i && count_done(timer_r, LOADER_CYCLES)) begin
                    state_nxt = S_USER;
                end
            end
            S_USER: begin
                if (loader_request_i) begin
                    state_nxt = S_LOADER;
                    timer_nxt = `TIMER_ZERO;
                    started_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = S_RESET;
            end
        endcase
        if (reset_req) begin
            state_nxt = S_RESET;
        end
        core_reset_nxt = (state_nxt == S_RESET);
        run_user_nxt = (state_nxt == S_USER);
        loader_nxt = (state_nxt == S_LOADER);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= S_RESET;
            timer_r <= `TIMER_ZERO;
            win_r <= `TIMER_ZERO;
            pending_r <= 1'b0;
            started_r <= 1'b0;
            bor_flag_r <= 1'b0;
            core_reset_r <= 1'b1;
            run_user_r <= 1'b0;
            loader_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            win_r <= win_nxt;
            pending_r <= pending_nxt;
            started_r <= started_nxt;
            bor_flag_r <= bor_flag_nxt;
            core_reset_r <= core_reset_nxt;
            run_user_r <= run_user_nxt;
            loader_r <= loader_nxt;
        end
    end

    led_fader #(
        .STEP_LAST(FADE_STEP_LAST)
    ) u_fader (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(loader_r),
        .pwm_o(led_o)
    );

    assign core_reset_o = core_reset_r;
    assign run_user_o = run_user_r;
    assign loader_active_o = loader_r;
    assign brownout_reset_flag_o = bor_flag_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_release;
        (state_r == S_RESET) && !reset_req;
    endsequence
    sequence s_decide;
        ##1 (state_r == S_SELECT) ##1 (state_r inside {S_WAIT, S_LOADER});
    endsequence

    property p_select_first;
        s_release |-> s_decide;
    endproperty
    a_select_first: assert property (p_select_first) else $error("No decision after reset");

    property p_single_to_user;
        (state_r == S_WAIT) && !pending_r && !reset_req |=> run_user_o;
    endproperty
    a_single_to_user: assert property (p_single_to_user) else $error("User not started");

    property p_wait_holds_user;
        (state_r == S_WAIT) && pending_r |=> !run_user_o;
    endproperty
    a_wait_holds_user: assert property (p_wait_holds_user) else $error("User ran early");

    property p_double_to_loader;
        (state_r == S_SELECT) && pending_r && !count_done(win_r, WINDOW_CYCLES) && !reset_req
            |=> loader_active_o && !pending_r;
    endproperty
    a_double_to_loader: assert property (p_double_to_loader) else $error("Loader not entered");

    property p_loader_timeout;
        (state_r == S_LOADER) && !started_r && !cmd_activity_i && !reset_req
            && count_done(timer_r, LOADER_CYCLES) |=> !loader_active_o && run_user_o;
    endproperty
    a_loader_timeout: assert property (p_loader_timeout) else $error("Loader timeout wrong");

    property p_no_timeout_after_cmd;
        (state_r == S_LOADER) && started_r && !reset_req |=> loader_active_o;
    endproperty
    a_no_timeout_after_cmd: assert property (p_no_timeout_after_cmd) else $error("Loader left after commands");

    property p_led_dark_outside;
        !loader_active_o [*2] |-> !led_o;
    endproperty
    a_led_dark_outside: assert property (p_led_dark_outside) else $error("LED lit outside loader");

    property p_bod_reset;
        bod_sync_r |=> core_reset_o && brownout_reset_flag_o;
    endproperty
    a_bod_reset: assert property (p_bod_reset) else $error("Brown-out did not reset");

    property p_flag_kept;
        brownout_reset_flag_o && !brownout_flag_clear_i |=> brownout_reset_flag_o;
    endproperty
    a_flag_kept: assert property (p_flag_kept) else $error("Brown-out flag lost");

    property p_usb_request;
        run_user_o && loader_request_i && !reset_req |=> loader_active_o;
    endproperty
    a_usb_request: assert property (p_usb_request) else $error("Loader request ignored");

    property p_pending_survives;
        $rose(core_reset_o) && pending_r && !count_done(win_r, WINDOW_CYCLES) |=> pending_r;
    endproperty
    a_pending_survives: assert property (p_pending_survives) else $error("Pending lost at reset");
endmodule : double_reset_boot_selector

// *** bench/host_cmd_model.sv ***
// Host side of the programming link: sends a burst of command bytes.
// Assumes the selector's clock; cmd_o is a one-cycle byte strobe.
`timescale 1ns/1ps

module host_cmd_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire logic [15:0] delay_i,
    output logic cmd_o
);
    logic [15:0] wait_r;
    logic [3:0] bytes_r;
    logic armed_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_r <= 16'h0000;
            bytes_r <= 4'h0;
            armed_r <= 1'b0;
            cmd_o <= 1'b0;
        end else begin
            cmd_o <= 1'b0;
            if (go_i) begin
                armed_r <= 1'b1;
                wait_r <= delay_i;
                bytes_r <= 4'h4;
            end else if (armed_r && wait_r != 16'h0000) begin
                wait_r <= wait_r - 16'h0001;
            end else if (armed_r) begin
                // Bytes spaced apart, as a slow host would send them
                cmd_o <= 1'b1;
                wait_r <= 16'h0002;
                bytes_r <= bytes_r - 4'h1;
                armed_r <= (bytes_r != 4'h1);
            end
        end
    end
endmodule : host_cmd_model

// *** bench/double_reset_boot_selector_test.sv ***
// Self-checking bench for the double-reset startup selector.
// Assumes short window, loader and fade step counts; host model drives command strobes.
`timescale 1ns/1ps

module double_reset_boot_selector_test;
    import boot_select_pkg::*;
    localparam int unsigned WIN = 200;
    localparam int unsigned LDR = 500;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ext_reset_n_i = 1'b1;
    logic brownout_i = 1'b0;
    logic cmd_activity_i;
    logic loader_request_i = 1'b0;
    logic brownout_flag_clear_i = 1'b0;
    logic host_go = 1'b0;
    logic [15:0] host_delay = 16'h0064;
    logic core_reset_o, run_user_o, loader_active_o, led_o, brownout_reset_flag_o;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    double_reset_boot_selector #(.WINDOW_CYCLES(WIN), .LOADER_CYCLES(LDR), .FADE_STEP_LAST(18'h00003)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ext_reset_n_i(ext_reset_n_i), .brownout_i(brownout_i),
        .cmd_activity_i(cmd_activity_i), .loader_request_i(loader_request_i),
        .brownout_flag_clear_i(brownout_flag_clear_i), .core_reset_o(core_reset_o),
        .run_user_o(run_user_o), .loader_active_o(loader_active_o), .led_o(led_o),
        .brownout_reset_flag_o(brownout_reset_flag_o));

    host_cmd_model u_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(host_go), .delay_i(host_delay),
        .cmd_o(cmd_activity_i));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Hang guard: the whole sequence needs well under this
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t timeout", $time);
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic check(input logic seen, input logic exp, input string what);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t %s seen %b expected %b", $time, what, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic wait_user(input int max);
        int k;
        k = 0;
        while (run_user_o !== 1'b1 && k < max) begin
            cyc(1);
            k = k + 1;
        end
    endtask : wait_user

    // Lit cycles over one PWM period
    task automatic led_count(output int n);
        n = 0;
        repeat (256) begin
            cyc(1);
            if (led_o === 1'b1) n = n + 1;
        end
    endtask : led_count

    task automatic press();
        ext_reset_n_i = 1'b0;
        cyc(6);
        check(core_reset_o, 1'b1, "core reset on press");
        check(run_user_o, 1'b0, "user stopped on press");
        ext_reset_n_i = 1'b1;
    endtask : press

    task automatic double_press();
        press();
        cyc(20);
        press();
        cyc(10);
        check(loader_active_o, 1'b1, "loader after double reset");
        check(run_user_o, 1'b0, "user held in loader");
    endtask : double_press

    task automatic t_single();
        press();
        cyc(WIN - 50);
        check(core_reset_o, 1'b0, "reset released");
        check(run_user_o, 1'b0, "user not before window");
        loader_request_i = 1'b1;
        cyc(1);
        loader_request_i = 1'b0;
        check(loader_active_o, 1'b0, "request ignored while waiting");
        wait_user(100);
        check(run_user_o, 1'b1, "user after window");
        check(loader_active_o, 1'b0, "no loader on single reset");
        $display("test single reset done");
    endtask : t_single

    task automatic t_timeout();
        double_press();
        cyc(LDR - 100);
        check(loader_active_o, 1'b1, "loader before timeout");
        wait_user(200);
        check(run_user_o, 1'b1, "user after loader timeout");
        check(loader_active_o, 1'b0, "loader left at timeout");
        cyc(3);
        check(led_o, 1'b0, "led dark outside loader");
        $display("test loader timeout done");
    endtask : t_timeout

    task automatic t_cmd_hold();
        int n_a, n_b, n_c, n_d;
        double_press();
        host_go = 1'b1;
        cyc(1);
        host_go = 1'b0;
        cyc(LDR + 300);
        check(loader_active_o, 1'b1, "loader kept after commands");
        check(run_user_o, 1'b0, "no user while programming");
        led_count(n_a);
        check(n_a > 0, 1'b1, "led lit in loader");
        cyc(500);
        led_count(n_b);
        check(n_b < n_a, 1'b1, "led fades out");
        cyc(400);
        led_count(n_c);
        led_count(n_d);
        check(n_d > n_c, 1'b1, "led fades in again");
        press();
        wait_user(WIN + 100);
        check(run_user_o, 1'b1, "user after later single reset");
        $display("test command hold done");
    endtask : t_cmd_hold

    task automatic t_request();
        loader_request_i = 1'b1;
        cyc(1);
        loader_request_i = 1'b0;
        check(loader_active_o, 1'b1, "loader on user request");
        check(run_user_o, 1'b0, "user left on request");
        cyc(LDR - 50);
        check(loader_active_o, 1'b1, "fresh loader window");
        wait_user(150);
        check(run_user_o, 1'b1, "user after request timeout");
        $display("test loader request done");
    endtask : t_request

    task automatic t_brownout();
        brownout_i = 1'b1;
        cyc(6);
        check(core_reset_o, 1'b1, "brown-out holds reset");
        check(brownout_reset_flag_o, 1'b1, "brown-out flag set");
        brownout_i = 1'b0;
        wait_user(WIN + 100);
        check(run_user_o, 1'b1, "user after brown-out");
        check(brownout_reset_flag_o, 1'b1, "flag kept by selector");
        press();
        wait_user(WIN + 100);
        check(brownout_reset_flag_o, 1'b1, "flag kept over button reset");
        brownout_flag_clear_i = 1'b1;
        cyc(1);
        brownout_flag_clear_i = 1'b0;
        cyc(1);
        check(brownout_reset_flag_o, 1'b0, "flag cleared by user");
        brownout_i = 1'b1;
        cyc(2);
        brownout_flag_clear_i = 1'b1;
        cyc(1);
        brownout_flag_clear_i = 1'b0;
        check(brownout_reset_flag_o, 1'b1, "brown-out wins over clear");
        brownout_i = 1'b0;
        wait_user(WIN + 100);
        check(run_user_o, 1'b1, "user after second brown-out");
        $display("test brown-out done");
    endtask : t_brownout

    initial begin
        cyc(20);
        rst_n_i = 1'b1;
        wait_user(WIN + 100);
        check(run_user_o, 1'b1, "user after power-on");
        check(brownout_reset_flag_o, 1'b0, "flag clear at power-on");
        t_single();
        t_timeout();
        t_cmd_hold();
        t_request();
        t_brownout();
        conclude();
    end
endmodule : double_reset_boot_selector_test
